// >>> pkg/cbc_pkg.sv
// Constants, register map and types of the automatic cell balance controller.
// Assumes a single 10 MHz clock and byte-wide register access at documented offsets.
// Overview of operation
// - Evaluate balance conditions once per voltage scan
// - Block balancing when temperature, current, voltage fail
// - Outputs only in on period, off during off
// - Decide on calibrated 14-bit converter cell results
// - Update lowest and highest cell at scan end
// - Flag cells above minimum by start delta
// - Excess spread sets cell failure, stops balancing
// - Under-voltage status with 117mV release hysteresis
// - Over-voltage status with 117mV release hysteresis
// - Only present cells join min, max, flags
// - No limit on simultaneous balance outputs
// - Latch cell set at on start, hold period
// - Stop while any temperature outside window
// - Control bit permits balancing during discharge
// - Control bit permits balancing during charge
// - At-full bit makes end-of-charge pin required
// - All three enable bits clear: no balancing
// - Power switch off pin disables all balancing
// - Sleep reads 0x000/0xFFF, restore after wake
// - Balance only after the selecting voltage scan
// - Host control bit hands outputs to host
package cbc_pkg;

  // Clock and timing
  localparam int unsigned CLK_KHZ          = 10000;
  localparam int unsigned TICK_US          = 1000;   // Balance timer unit
  localparam int unsigned TICK_CYC_DEF     = TICK_US * CLK_KHZ / 1000;
  localparam int unsigned RESTORE_US       = 538;    // Wake restore bound
  localparam int unsigned RESTORE_CYC      = RESTORE_US * CLK_KHZ / 1000;

  // Widths
  localparam int unsigned ADC_W            = 14;
  localparam int unsigned VOLT_W           = 12;
  localparam int unsigned TMR_W            = 12;
  localparam int unsigned NCELL            = 8;

  // Hysteresis of 117 mV at 4.8 V full scale over 12 bits, rounded to nearest
  localparam int unsigned HYST_MV          = 117;
  localparam int unsigned FULL_MV          = 4800;
  localparam logic [VOLT_W-1:0] HYST_CODE  =
    VOLT_W'((HYST_MV * 4096 + FULL_MV / 2) / FULL_MV);

  // Sleep read values
  localparam logic [15:0] SLEEP_MIN_VAL    = 16'h0000;
  localparam logic [15:0] SLEEP_MAX_VAL    = 16'h0FFF;

  // Register byte offsets
  localparam logic [7:0] OFS_LOWER_LIM     = 8'h1C;
  localparam logic [7:0] OFS_UPPER_LIM     = 8'h1E;
  localparam logic [7:0] OFS_START_DELTA   = 8'h20;
  localparam logic [7:0] OFS_FAIL_DELTA    = 8'h22;
  localparam logic [7:0] OFS_ON_TIME       = 8'h24;
  localparam logic [7:0] OFS_OFF_TIME      = 8'h26;
  localparam logic [7:0] OFS_LOW_TEMP      = 8'h28;
  localparam logic [7:0] OFS_HIGH_TEMP     = 8'h2C;
  localparam logic [7:0] OFS_CELL_SEL      = 8'h49;
  localparam logic [7:0] OFS_BAL_CFG       = 8'h4B;
  localparam logic [7:0] OFS_FAIL_STAT     = 8'h81;
  localparam logic [7:0] OFS_BAL_STAT      = 8'h83;
  localparam logic [7:0] OFS_FLAGS         = 8'h84;
  localparam logic [7:0] OFS_HOST_CTRL     = 8'h87;
  localparam logic [7:0] OFS_LOWEST        = 8'h8A;
  localparam logic [7:0] OFS_HIGHEST       = 8'h8C;

  // Bit positions
  localparam int unsigned BIT_DISCH_EN     = 7;
  localparam int unsigned BIT_CHG_EN       = 6;
  localparam int unsigned BIT_FULL_EN      = 0;
  localparam int unsigned BIT_CELL_FAIL    = 4;
  localparam int unsigned BIT_UNDERVOLT    = 3;
  localparam int unsigned BIT_OVERVOLT     = 2;
  localparam int unsigned BIT_HOST_BAL     = 5;
  localparam int unsigned BIT_HOST_ON      = 0;

  // Reset values
  localparam logic [15:0] RST_WORD         = 16'h0000;
  localparam logic [7:0]  RST_CELL_SEL     = 8'hFF;
  localparam logic [7:0]  RST_BYTE         = 8'h00;

  // Balance sequencer states
  typedef enum logic [1:0] {
    CBC_WAIT,
    CBC_ON,
    CBC_OFF
  } cbc_state_e;

endpackage : cbc_pkg

// >>> rtl/cbc_balance_ctrl.sv
// Automatic cell balance controller: min/max tracking, interlocks, on/off sequencer.
// Assumes scan results arrive on clk, and the two pins arrive asynchronously.
module cbc_balance_ctrl #(
  parameter int unsigned TICK_CYCLES = cbc_pkg::TICK_CYC_DEF
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  // Register access port
  input  wire logic [7:0]                    reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  // Voltage scan results
  input  wire logic                          scan_cell_valid,
  input  wire logic [2:0]                    scan_cell_index,
  input  wire logic [cbc_pkg::ADC_W-1:0]     scan_cell_code,
  input  wire logic                          scan_done,
  input  wire logic [cbc_pkg::VOLT_W-1:0]    temp1_code,
  input  wire logic [cbc_pkg::VOLT_W-1:0]    temp2_code,
  // Current direction and mode
  input  wire logic                          charge_current_seen,
  input  wire logic                          discharge_current_seen,
  input  wire logic                          sleep_active,
  // Pins
  input  wire logic                          full_charge_pin,
  input  wire logic                          power_switch_off_pin,
  // Balance drivers
  output logic      [cbc_pkg::NCELL-1:0]     balance_driver_output
);
  import cbc_pkg::*;

  // Register storage
  logic [15:0]        lower_lim_r, upper_lim_r, start_delta_r, fail_delta_r;
  logic [15:0]        on_time_r, off_time_r, low_temp_r, high_temp_r;
  logic [7:0]         cells_present_select_r;
  logic [7:0]         bal_cfg_r;
  logic [7:0]         host_ctrl_r;
  logic [NCELL-1:0]   balance_flags_r;
  logic [VOLT_W-1:0]  lowest_r, highest_r;
  logic               cell_failure_flag_r;
  logic               undervolt_r, overvolt_r;
  logic               permit_r;
  logic               scan_fresh_r;
  logic [VOLT_W-1:0]  cell_v_r [NCELL];

  // Pin synchronisers
  logic [1:0]         full_sync_r, off_sync_r;

  // Sequencer
  cbc_state_e         state_r, state_nxt;
  logic [TMR_W-1:0]   tmr_r;
  logic [31:0]        tick_cnt_r;
  logic               tick;
  logic [NCELL-1:0]   active_set_r;

  // Combinational scan results
  logic [VOLT_W-1:0]  min_nxt, max_nxt;
  logic [NCELL-1:0]   flags_nxt;
  logic               fail_nxt, uv_nxt, ov_nxt, permit_nxt;
  logic               temp_ok, current_ok, pins_ok;
  logic               host_mode;
  logic [7:0]         rd_byte;

  // Greater-than test on a difference against a delta
  function automatic logic exceeds(input logic [VOLT_W-1:0] v,
                                   input logic [VOLT_W-1:0] base,
                                   input logic [VOLT_W-1:0] delta);
    logic [VOLT_W:0] diff;
    diff = {1'b0, v} - {1'b0, base};
    return (v > base) && (diff > {1'b0, delta});
  endfunction : exceeds

  // Pick one byte of a 16-bit register by address parity
  function automatic logic [7:0] byte_of(input logic [15:0] w, input logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction : byte_of

  assign host_mode = host_ctrl_r[BIT_HOST_BAL];

  // Two flops before any logic reads a pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      full_sync_r <= 2'b00;
      off_sync_r  <= 2'b00;
    end else begin
      full_sync_r <= {full_sync_r[0], full_charge_pin};
      off_sync_r  <= {off_sync_r[0], power_switch_off_pin};
    end
  end

  // Cell result capture; upper 12 bits of the calibrated 14-bit code
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NCELL; i++) begin
        cell_v_r[i] <= '0;
      end
    end else if (scan_cell_valid) begin
      cell_v_r[scan_cell_index] <= scan_cell_code[ADC_W-1 -: VOLT_W];
    end
  end

  // Min and max over present cells only
  always_comb begin
    logic first;
    first   = 1'b1;
    min_nxt = '0;
    max_nxt = '0;
    for (int i = 0; i < NCELL; i++) begin
      if (cells_present_select_r[i]) begin
        if (first || cell_v_r[i] < min_nxt) min_nxt = cell_v_r[i];
        if (first || cell_v_r[i] > max_nxt) max_nxt = cell_v_r[i];
        first = 1'b0;
      end
    end
  end

  // Cell flags and spread failure against the new minimum
  always_comb begin
    flags_nxt = '0;
    for (int i = 0; i < NCELL; i++) begin
      flags_nxt[i] = cells_present_select_r[i] &&
                     exceeds(cell_v_r[i], min_nxt, start_delta_r[VOLT_W-1:0]);
    end
    fail_nxt = exceeds(max_nxt, min_nxt, fail_delta_r[VOLT_W-1:0]);
  end

  // Voltage window with release hysteresis
  always_comb begin
    uv_nxt = undervolt_r;
    ov_nxt = overvolt_r;
    if (max_nxt < lower_lim_r[VOLT_W-1:0]) begin
      uv_nxt = 1'b1;
    end else if ({1'b0, max_nxt} >
                 ({1'b0, lower_lim_r[VOLT_W-1:0]} + {1'b0, HYST_CODE})) begin
      uv_nxt = 1'b0;
    end
    if (min_nxt > upper_lim_r[VOLT_W-1:0]) begin
      ov_nxt = 1'b1;
    end else if ({1'b0, min_nxt} + {1'b0, HYST_CODE} <
                 {1'b0, upper_lim_r[VOLT_W-1:0]}) begin
      ov_nxt = 1'b0;
    end
  end

  // Temperature window, current and pin conditions
  always_comb begin
    // Thermistor code falls as temperature rises: cold limit is the larger code
    temp_ok = (temp1_code <= low_temp_r[VOLT_W-1:0]) &&
              (temp1_code >= high_temp_r[VOLT_W-1:0]) &&
              (temp2_code <= low_temp_r[VOLT_W-1:0]) &&
              (temp2_code >= high_temp_r[VOLT_W-1:0]);
    current_ok = (bal_cfg_r[BIT_DISCH_EN] && discharge_current_seen &&
                  !charge_current_seen) ||
                 (bal_cfg_r[BIT_CHG_EN] && charge_current_seen &&
                  !discharge_current_seen) ||
                 (bal_cfg_r[BIT_FULL_EN] && full_sync_r[1]);
    // With the at-full bit set the pin is mandatory; clear, it is ignored
    pins_ok    = !bal_cfg_r[BIT_FULL_EN] || full_sync_r[1];
    // All enable bits clear leaves current_ok false: nothing balances
    permit_nxt = temp_ok && current_ok && pins_ok && !fail_nxt &&
                 !uv_nxt && !ov_nxt;
  end

  // Scan-end bookkeeping, once per scan
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lowest_r            <= '0;
      highest_r           <= '0;
      cell_failure_flag_r <= 1'b0;
      undervolt_r         <= 1'b0;
      overvolt_r          <= 1'b0;
      permit_r            <= 1'b0;
    end else if (scan_done) begin
      lowest_r            <= min_nxt;
      highest_r           <= max_nxt;
      cell_failure_flag_r <= fail_nxt;
      undervolt_r         <= uv_nxt;
      overvolt_r          <= ov_nxt;
      permit_r            <= permit_nxt;
    end
  end

  // Marks a scan not yet consumed by an on-period start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_fresh_r <= 1'b0;
    end else if (scan_done) begin
      scan_fresh_r <= 1'b1;
    end else if (state_r != CBC_ON && state_nxt == CBC_ON) begin
      scan_fresh_r <= 1'b0;
    end
  end

  // Timer prescaler; free-running time base for both balance timers
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'd1;
    end
  end

  // Sequencer next state; a dropped permit or the off pin aborts at once
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CBC_WAIT: begin
        if (permit_r && scan_fresh_r && !off_sync_r[1] && !host_mode) begin
          state_nxt = CBC_ON;
        end
      end
      CBC_ON: begin
        if (!permit_r || off_sync_r[1] || host_mode) begin
          state_nxt = CBC_WAIT;
        end else if (tick && tmr_r == '0) begin
          state_nxt = CBC_OFF;
        end
      end
      CBC_OFF: begin
        if (!permit_r || off_sync_r[1] || host_mode) begin
          state_nxt = CBC_WAIT;
        end else if (tick && tmr_r == '0) begin
          state_nxt = CBC_ON;
        end
      end
      default: state_nxt = CBC_WAIT;
    endcase
  end

  // Sequencer state and 12-bit timers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= CBC_WAIT;
      tmr_r   <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt == CBC_ON && state_r != CBC_ON) begin
        tmr_r <= on_time_r[TMR_W-1:0];
      end else if (state_nxt == CBC_OFF && state_r != CBC_OFF) begin
        tmr_r <= off_time_r[TMR_W-1:0];
      end else if (tick && tmr_r != '0) begin
        tmr_r <= tmr_r - TMR_W'(1);
      end
    end
  end

  // Cell set latched on entry to each on period, held through the off period
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_set_r <= '0;
    end else if (state_nxt == CBC_ON && state_r != CBC_ON) begin
      active_set_r <= balance_flags_r & cells_present_select_r;
    end
  end

  // Driver outputs: any number of cells at once; host path bypasses sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      balance_driver_output <= '0;
    end else if (off_sync_r[1]) begin
      balance_driver_output <= '0;
    end else if (host_mode) begin
      balance_driver_output <= host_ctrl_r[BIT_HOST_ON] ?
                               balance_flags_r : '0;
    end else if (state_nxt == CBC_ON) begin
      balance_driver_output <= (state_r == CBC_ON) ? active_set_r :
                               (balance_flags_r & cells_present_select_r);
    end else begin
      balance_driver_output <= '0;
    end
  end

  // Balance flags: written by the scan at scan end in auto mode, by the host at any other time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      balance_flags_r <= '0;
    end else if (scan_done && !host_mode) begin
      balance_flags_r <= flags_nxt;
    end else if (reg_wr && reg_addr == OFS_FLAGS) begin
      balance_flags_r <= reg_wdata;
    end
  end

  // Software-written configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lower_lim_r            <= RST_WORD;
      upper_lim_r            <= RST_WORD;
      start_delta_r          <= RST_WORD;
      fail_delta_r           <= RST_WORD;
      on_time_r              <= RST_WORD;
      off_time_r             <= RST_WORD;
      low_temp_r             <= RST_WORD;
      high_temp_r            <= RST_WORD;
      cells_present_select_r <= RST_CELL_SEL;
      bal_cfg_r              <= RST_BYTE;
      host_ctrl_r            <= RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_LOWER_LIM:          lower_lim_r[7:0]    <= reg_wdata;
        OFS_LOWER_LIM + 8'h01:  lower_lim_r[15:8]   <= reg_wdata;
        OFS_UPPER_LIM:          upper_lim_r[7:0]    <= reg_wdata;
        OFS_UPPER_LIM + 8'h01:  upper_lim_r[15:8]   <= reg_wdata;
        OFS_START_DELTA:        start_delta_r[7:0]  <= reg_wdata;
        OFS_START_DELTA + 8'h01: start_delta_r[15:8] <= reg_wdata;
        OFS_FAIL_DELTA:         fail_delta_r[7:0]   <= reg_wdata;
        OFS_FAIL_DELTA + 8'h01: fail_delta_r[15:8]  <= reg_wdata;
        OFS_ON_TIME:            on_time_r[7:0]      <= reg_wdata;
        OFS_ON_TIME + 8'h01:    on_time_r[15:8]     <= reg_wdata;
        OFS_OFF_TIME:           off_time_r[7:0]     <= reg_wdata;
        OFS_OFF_TIME + 8'h01:   off_time_r[15:8]    <= reg_wdata;
        OFS_LOW_TEMP:           low_temp_r[7:0]     <= reg_wdata;
        OFS_LOW_TEMP + 8'h01:   low_temp_r[15:8]    <= reg_wdata;
        OFS_HIGH_TEMP:          high_temp_r[7:0]    <= reg_wdata;
        OFS_HIGH_TEMP + 8'h01:  high_temp_r[15:8]   <= reg_wdata;
        OFS_CELL_SEL:           cells_present_select_r <= reg_wdata;
        OFS_BAL_CFG:            bal_cfg_r           <= reg_wdata;
        OFS_HOST_CTRL:          host_ctrl_r         <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read mux; sleep substitutes fixed values, wake shows held values again
  always_comb begin
    logic [15:0] lo_word;
    logic [15:0] hi_word;
    lo_word = sleep_active ? SLEEP_MIN_VAL : 16'(lowest_r);
    hi_word = sleep_active ? SLEEP_MAX_VAL : 16'(highest_r);
    rd_byte = 8'h00;
    case (reg_addr & 8'hFE)
      OFS_LOWER_LIM:   rd_byte = byte_of(lower_lim_r, reg_addr[0]);
      OFS_UPPER_LIM:   rd_byte = byte_of(upper_lim_r, reg_addr[0]);
      OFS_START_DELTA: rd_byte = byte_of(start_delta_r, reg_addr[0]);
      OFS_FAIL_DELTA:  rd_byte = byte_of(fail_delta_r, reg_addr[0]);
      OFS_ON_TIME:     rd_byte = byte_of(on_time_r, reg_addr[0]);
      OFS_OFF_TIME:    rd_byte = byte_of(off_time_r, reg_addr[0]);
      OFS_LOW_TEMP:    rd_byte = byte_of(low_temp_r, reg_addr[0]);
      OFS_HIGH_TEMP:   rd_byte = byte_of(high_temp_r, reg_addr[0]);
      OFS_LOWEST:      rd_byte = byte_of(lo_word, reg_addr[0]);
      OFS_HIGHEST:     rd_byte = byte_of(hi_word, reg_addr[0]);
      default: begin
        case (reg_addr)
          OFS_CELL_SEL:  rd_byte = cells_present_select_r;
          OFS_BAL_CFG:   rd_byte = bal_cfg_r;
          OFS_HOST_CTRL: rd_byte = host_ctrl_r;
          OFS_FLAGS:     rd_byte = balance_flags_r;
          OFS_FAIL_STAT: rd_byte = 8'(cell_failure_flag_r) << BIT_CELL_FAIL;
          OFS_BAL_STAT:  rd_byte = (8'(undervolt_r) << BIT_UNDERVOLT) |
                                   (8'(overvolt_r) << BIT_OVERVOLT);
          default:       rd_byte = 8'h00;
        endcase
      end
    endcase
  end

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_byte;
    end
  end

endmodule : cbc_balance_ctrl

// >>> verification/cbc_balance_ctrl_asserts.sv
// Port-level checker for cbc_balance_ctrl: read timing, driver timing, interlocks.
// Assumes TICK_CYCLES of four or more, so a driver set stands at least four cycles.
module cbc_balance_chk #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Scan, mode and pin
  input wire logic       scan_done,
  input wire logic       sleep_active,
  input wire logic       power_switch_off_pin,
  // Drivers
  input wire logic [7:0] balance_driver_output
);
  import cbc_pkg::*;
  logic [7:0] cfg_r;
  // Shadow of the enable byte, so the checker knows when nothing may balance
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= RST_BYTE;
    end else if (reg_wr && reg_addr == OFS_BAL_CFG) begin
      cfg_r <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_release_drivers_off: assert property (
    $rose(arst_n) |-> balance_driver_output == 8'h00) else $error("drivers on after reset");
  a_pin_kills_drivers: assert property (
    power_switch_off_pin [*5] |-> balance_driver_output == 8'h00) else $error("drivers on, pin");
  a_no_enable_idle: assert property (
    scan_done && !cfg_r[BIT_DISCH_EN] && !cfg_r[BIT_CHG_EN] && !cfg_r[BIT_FULL_EN]
    |-> ##3 balance_driver_output == 8'h00) else $error("drivers on with enables clear");
  a_set_holds: assert property (
    $changed(balance_driver_output) && balance_driver_output != 8'h00
    |=> ($stable(balance_driver_output) || balance_driver_output == 8'h00) [*3])
    else $error("driver set changed within a tick");
  a_read_holds: assert property (
    !$past(reg_rd) |-> $stable(reg_rdata)) else $error("read byte moved without a read");
  a_sleep_lowest: assert property (
    reg_rd && sleep_active && reg_addr == OFS_LOWEST |=> reg_rdata == SLEEP_MIN_VAL[7:0])
    else $error("lowest cell not cleared in sleep");
  a_sleep_highest_lo: assert property (
    reg_rd && sleep_active && reg_addr == OFS_HIGHEST |=> reg_rdata == SLEEP_MAX_VAL[7:0])
    else $error("highest cell low byte wrong in sleep");
  a_sleep_highest_hi: assert property (
    reg_rd && sleep_active && reg_addr == OFS_HIGHEST + 8'h01
    |=> reg_rdata == SLEEP_MAX_VAL[15:8]) else $error("highest cell high byte wrong in sleep");
  c_balance_start: cover property (scan_done ##3 balance_driver_output != 8'h00);
  c_pin_kill: cover property (power_switch_off_pin [*5]);
  c_sleep_read: cover property (reg_rd && sleep_active);
endmodule : cbc_balance_chk

bind cbc_balance_ctrl cbc_balance_chk #(.TICK_CYCLES(TICK_CYCLES)) i_cbc_balance_chk (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scan_done(scan_done), .sleep_active(sleep_active),
  .power_switch_off_pin(power_switch_off_pin), .balance_driver_output(balance_driver_output));

// >>> verification/cbc_fet_model.sv
// Behavioural model of the external balance FET bank across the cells.
// Assumes active-high gate drive; reports the most FETs seen conducting at once.
module cbc_fet_model (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // Gate drive from the controller
  input  wire logic [cbc_pkg::NCELL-1:0] gate,
  // Observation
  output logic      [3:0]                peak
);
  // Current flows outside the chip, so any number of FETs may conduct together
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      peak <= 4'h0;
    end else if (4'($countones(gate)) > peak) begin
      peak <= 4'($countones(gate));
    end
  end
endmodule : cbc_fet_model

// >>> verification/cbc_balance_ctrl_tb.sv
// Self-checking bench for the cell balance controller with a FET bank model.
// Assumes the checker binds itself; timer tick scaled down to 4 clocks.
module cbc_balance_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cbc_pkg::*;
  logic        clk, arst_n, reg_wr, reg_rd, scan_cell_valid, scan_done, sleep_active;
  logic        charge_current_seen, discharge_current_seen, full_charge_pin;
  logic        power_switch_off_pin, rd_d, pr, pr_d;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, balance_driver_output, fl;
  logic [2:0]  scan_cell_index;
  logic [13:0] scan_cell_code;
  logic [11:0] temp_code, mn, mx, v [8];
  logic [3:0]  peak;
  logic [31:0] seed = 32'h6F37;
  logic [7:0]  q [$];
  logic [11:0] mode [8] = '{12'h181, 12'h100, 12'h640, 12'h140, 12'h3C0, 12'h280,
    12'h980, 12'h580};
  logic [15:0] hy [6] = '{16'h80F0, 16'h8150, 16'h0170, 16'h4F10, 16'h4EB0, 16'h0E90};
  int          fail_count, n_compared, cyc;

  cbc_balance_ctrl #(.TICK_CYCLES(4)) i_cbc_balance_ctrl (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scan_cell_valid(scan_cell_valid), .scan_cell_index(scan_cell_index),
    .scan_cell_code(scan_cell_code), .scan_done(scan_done), .temp1_code(temp_code),
    .temp2_code(temp_code), .charge_current_seen(charge_current_seen),
    .discharge_current_seen(discharge_current_seen), .sleep_active(sleep_active),
    .full_charge_pin(full_charge_pin), .power_switch_off_pin(power_switch_off_pin),
    .balance_driver_output(balance_driver_output));
  cbc_fet_model i_cbc_fet_model (.clk(clk), .arst_n(arst_n), .gate(balance_driver_output),
    .peak(peak));

  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h8020_0003 : s >> 1;
  endfunction : lfsr

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // Watcher: oldest note against whatever result appears; also the hang limit
  always @(posedge clk) begin
    if (rd_d === 1'b1) chk("reg_rdata", reg_rdata, q.pop_front());
    if (pr_d === 1'b1) chk("drivers", balance_driver_output, q.pop_front());
    rd_d <= reg_rd;
    pr_d <= pr;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask : wr16

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd_chk

  // Probe the drivers; the watcher compares two edges later
  task automatic out_chk(input int n, input logic [7:0] e);
    repeat (n) @(posedge clk);
    @(posedge clk);
    pr <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    pr <= 1'b0;
  endtask : out_chk

  // One full cell scan; low two code bits are random and must not matter
  task automatic scan;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      seed = lfsr(seed);
      {scan_cell_valid, scan_cell_index, scan_cell_code} <= {1'b1, 3'(i), v[i], seed[1:0]};
    end
    @(posedge clk);
    {scan_cell_valid, scan_done} <= 2'b01;
    @(posedge clk);
    scan_done <= 1'b0;
  endtask : scan

  // Pin kills any running period before the next scan
  task automatic quiet;
    @(posedge clk);
    power_switch_off_pin <= 1'b1;
    out_chk(6, 8'h00);
    power_switch_off_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : quiet

  initial begin
    {reg_wr, reg_rd, scan_cell_valid, scan_done, pr, rd_d, pr_d, sleep_active} = '0;
    {charge_current_seen, full_charge_pin, power_switch_off_pin, cyc} = '0;
    {reg_addr, reg_wdata, scan_cell_index, scan_cell_code} = '0;
    {discharge_current_seen, temp_code, arst_n} = {1'b1, 12'h800, 1'b0};
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(OFS_CELL_SEL, RST_CELL_SEL);
    rd_chk(OFS_BAL_CFG, RST_BYTE);
    rd_chk(8'hF0, 8'h00);
    // Limits, deltas, timers, temperature window, cell 7 absent, discharge enable
    wr16(OFS_LOWER_LIM, 16'h0100);
    wr16(OFS_UPPER_LIM, 16'h0F00);
    wr16(OFS_START_DELTA, 16'h0010);
    wr16(OFS_FAIL_DELTA, 16'h0200);
    wr16(OFS_ON_TIME, 16'h0003);
    wr16(OFS_OFF_TIME, 16'h0003);
    wr16(OFS_LOW_TEMP, 16'h0FFF);
    wr16(OFS_HIGH_TEMP, 16'h0100);
    wr(OFS_CELL_SEL, 8'h7F);
    wr(OFS_BAL_CFG, 8'h80);
    // Absent cell 7 is lowest of all and must be ignored
    {mx, fl, v[0], v[7]} = {12'h000, 8'h00, 12'h7C0, 12'h100};
    for (int i = 1; i < 7; i++) begin
      seed = lfsr(seed);
      v[i] = 12'h800 + 12'(seed[5:0]);
      mx = (v[i] > mx) ? v[i] : mx;
      fl[i] = 1'b1;
    end
    mn = v[0];
    scan();
    out_chk(1, fl);
    out_chk(21, 8'h00);
    out_chk(11, fl);
    chk("peak", {4'h0, peak}, 8'h06);
    rd_chk(OFS_LOWEST, mn[7:0]);
    rd_chk(OFS_LOWEST + 8'h01, {4'h0, mn[11:8]});
    rd_chk(OFS_HIGHEST, mx[7:0]);
    rd_chk(OFS_FLAGS, fl);
    // Current direction, enable bits and temperature window
    for (int k = 0; k < 8; k++) begin
      quiet();
      {charge_current_seen, discharge_current_seen} <= mode[k][9:8];
      temp_code <= mode[k][11] ? 12'h050 : 12'h800;
      wr(OFS_BAL_CFG, mode[k][7:0]);
      scan();
      out_chk(1, mode[k][10] ? fl : 8'h00);
    end
    // Under and over limits with release hysteresis, uniform cells
    for (int k = 0; k < 6; k++) begin
      v = '{default: hy[k][11:0]};
      scan();
      rd_chk(OFS_BAL_STAT, {4'h0, hy[k][15:12]});
    end
    // Spread beyond the fail delta stops balancing of a flagged cell
    v = '{default: 12'h500};
    v[3] = 12'h800;
    quiet();
    scan();
    out_chk(1, 8'h00);
    rd_chk(OFS_FAIL_STAT, 8'h01 << BIT_CELL_FAIL);
    wr(OFS_HIGHEST, 8'h55);
    sleep_active <= 1'b1;
    rd_chk(OFS_LOWEST, 8'h00);
    rd_chk(OFS_HIGHEST, 8'hFF);
    rd_chk(OFS_HIGHEST + 8'h01, 8'h0F);
    sleep_active <= 1'b0;
    rd_chk(OFS_HIGHEST, 8'h00);
    rd_chk(OFS_HIGHEST + 8'h01, 8'h08);
    wr(OFS_HOST_CTRL, 8'h21);
    out_chk(1, 8'h08);
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule : cbc_balance_ctrl_tb
